// *** hw/gpd_map.svh ***
/*
  Address map, field positions, masks and reset values of the three
  port pin-control registers. Assumes byte addressing on a 32-bit bus.
*/
`ifndef GPD_MAP_SVH
`define GPD_MAP_SVH

// Register byte addresses
`define GPD_PORT0_ADDR   32'hFFFF0D20
`define GPD_PORT1_ADDR   32'hFFFF0D30
`define GPD_PORT2_ADDR   32'hFFFF0D40

// Field positions, common to all ports: pin k sits at field base + k
`define GPD_DIR_LSB      5'd24
`define GPD_OUT_LSB      5'd16
`define GPD_IN_LSB       5'd0
`define GPD_FIELD_W      8

// Implemented bits of each register
`define GPD_P0_DIR_MASK  32'h1F000000
`define GPD_P0_OUT_MASK  32'h001F0000
`define GPD_P0_IN_MASK   32'h0000001F
`define GPD_P1_DIR_MASK  32'h03000000
`define GPD_P1_OUT_MASK  32'h00030000
`define GPD_P1_IN_MASK   32'h00000003
`define GPD_P2_DIR_MASK  32'h73000000
`define GPD_P2_OUT_MASK  32'h00630000
`define GPD_P2_IN_MASK   32'h00000073

// Reset values of direction and output fields
`define GPD_DIR_RESET    8'h00
`define GPD_OUT_RESET    8'h00

// Pin counts
`define GPD_P0_PINS      5
`define GPD_P1_PINS      2
`define GPD_P2_PINS      7
`define GPD_ALL_PINS     14

// Answer on unmapped addresses
`define GPD_UNMAPPED_DATA 32'h00000000

`endif

// *** hw/gpd_pkg.sv ***
/*
  Types shared by the pin-control register block.
  Assumes gpd_map.svh supplies the numeric constants.
*/
package gpd_pkg;

  typedef enum logic [1:0] {
    GPD_PORT0,
    GPD_PORT1,
    GPD_PORT2,
    GPD_NONE
  } gpd_port_e;

  typedef logic [7:0]  gpd_field_t;
  typedef logic [31:0] gpd_word_t;

endpackage

// *** hw/gpd_pin_sync.sv ***
/*
  Two-stage synchroniser for the asynchronous pin inputs.
  Assumes an active-low reset whose release is already synchronised to clock.
*/
module gpd_pin_sync #(
  parameter int WIDTH = 14
) (
  input  wire logic             clock,
  input  wire logic             rstN,
  input  wire logic [WIDTH-1:0] pinAsync,
  output logic      [WIDTH-1:0] pinSync
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync;

  ////////////////////////////////////////////////////////////////////////////
  // Meta stage feeds only the second stage
  for (genvar i = 0; i < WIDTH; i++) begin : gBit
    always_comb begin
      next_meta[i] = pinAsync[i];
      next_sync[i] = meta[i];
    end
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      meta    <= '0;
      pinSync <= '0;
    end else begin
      meta    <= next_meta;
      pinSync <= next_sync;
    end
  end

endmodule

// *** hw/gpd_port_regs.sv ***
/*
  Pin-control registers for three general-purpose ports, one 32-bit
  word each, holding direction, output value and live input level.
  Assumes a classic Wishbone master on the same clock and pins that
  are asynchronous to it.
*/
//
// Function
// - Three read/write port words at fixed addresses
// - Input bits return the current pin level
// - Port0 bits 28..24 set pin direction
// - Port0 bits 20..16 drive pin outputs
// - Port0 bits 4..0 read-only pin status
// - Port1 bits 25..24 set pin direction
// - Port1 bits 17..16 drive pin outputs
// - Port1 bits 1..0 report pin levels
// - Port2 sparse direction, output, input bits
`include "gpd_map.svh"

module gpd_port_regs (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [31:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic [4:0]  p0PinIn,
  output logic      [4:0]  p0PinOut,
  output logic      [4:0]  p0PinOe,
  input  wire logic [1:0]  p1PinIn,
  output logic      [1:0]  p1PinOut,
  output logic      [1:0]  p1PinOe,
  input  wire logic [6:0]  p2PinIn,
  output logic      [6:0]  p2PinOut,
  output logic      [6:0]  p2PinOe
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops

  logic rstMetaN;
  logic rstSyncN;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rstMetaN <= 1'b0;
      rstSyncN <= 1'b0;
    end else begin
      rstMetaN <= 1'b1;
      rstSyncN <= rstMetaN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin input synchronisation

  logic [`GPD_ALL_PINS-1:0] pinLevel;
  gpd_pkg::gpd_field_t      inVec [3];

  gpd_pin_sync #(
    .WIDTH (`GPD_ALL_PINS)
  ) uPinSync (
    .clock    (clock),
    .rstN     (rstSyncN),
    .pinAsync ({p2PinIn, p1PinIn, p0PinIn}),
    .pinSync  (pinLevel)
  );

  // Port2 pins 2 and 3 have no register bits; their levels are masked on read
  always_comb begin
    inVec[0] = {3'h0, pinLevel[4:0]};
    inVec[1] = {6'h00, pinLevel[6:5]};
    inVec[2] = {1'b0, pinLevel[13:7]};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  function automatic gpd_pkg::gpd_port_e portOf(input logic [31:0] adr);
    gpd_pkg::gpd_port_e hit;
    hit = gpd_pkg::GPD_NONE;
    if (adr == `GPD_PORT0_ADDR) begin
      hit = gpd_pkg::GPD_PORT0;
    end else if (adr == `GPD_PORT1_ADDR) begin
      hit = gpd_pkg::GPD_PORT1;
    end else if (adr == `GPD_PORT2_ADDR) begin
      hit = gpd_pkg::GPD_PORT2;
    end
    return hit;
  endfunction

  // Bits that software may change in a port word
  function automatic gpd_pkg::gpd_word_t writeMask(input gpd_pkg::gpd_port_e p);
    gpd_pkg::gpd_word_t m;
    m = 32'h00000000;
    unique case (p)
      gpd_pkg::GPD_PORT0: m = `GPD_P0_DIR_MASK | `GPD_P0_OUT_MASK;
      gpd_pkg::GPD_PORT1: m = `GPD_P1_DIR_MASK | `GPD_P1_OUT_MASK;
      gpd_pkg::GPD_PORT2: m = `GPD_P2_DIR_MASK | `GPD_P2_OUT_MASK;
      gpd_pkg::GPD_NONE:  m = 32'h00000000;
    endcase
    return m;
  endfunction

  function automatic gpd_pkg::gpd_word_t inMask(input gpd_pkg::gpd_port_e p);
    gpd_pkg::gpd_word_t m;
    m = 32'h00000000;
    unique case (p)
      gpd_pkg::GPD_PORT0: m = `GPD_P0_IN_MASK;
      gpd_pkg::GPD_PORT1: m = `GPD_P1_IN_MASK;
      gpd_pkg::GPD_PORT2: m = `GPD_P2_IN_MASK;
      gpd_pkg::GPD_NONE:  m = 32'h00000000;
    endcase
    return m;
  endfunction

  function automatic gpd_pkg::gpd_word_t laneMask(input logic [3:0] sel);
    return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake

  gpd_pkg::gpd_port_e hitPort;
  logic               busReq;
  logic               wrCommit;
  logic               next_ack;
  logic [31:0]        next_dat;

  gpd_pkg::gpd_field_t dirReg   [3];
  gpd_pkg::gpd_field_t outReg   [3];
  gpd_pkg::gpd_field_t next_dir [3];
  gpd_pkg::gpd_field_t next_out [3];

  always_comb begin
    hitPort = portOf(adr_i);
    busReq  = cyc_i & stb_i;
    // Write lands on the edge where the master sees ack, so data is held stable
    wrCommit = busReq & we_i & ack_o;
  end

  // Read word: direction, output, live input; reserved bits read as zero
  always_comb begin
    next_ack = busReq & ~ack_o;
    next_dat = dat_o;
    if (busReq & ~ack_o) begin
      next_dat = `GPD_UNMAPPED_DATA;
      if (hitPort != gpd_pkg::GPD_NONE) begin
        next_dat = ({dirReg[hitPort], outReg[hitPort], 8'h00, 8'h00}
                    & writeMask(hitPort))
                 | ({24'h000000, inVec[hitPort]} & inMask(hitPort));
      end
    end
  end

  always_ff @(posedge clock or negedge rstSyncN) begin
    if (!rstSyncN) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= next_ack;
      dat_o <= next_dat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Direction and output fields, one copy per port

  for (genvar p = 0; p < 3; p++) begin : gPort
    gpd_pkg::gpd_word_t wm;

    // Status and reserved positions are outside the mask, so writes there are lost
    always_comb begin
      wm          = writeMask(gpd_pkg::gpd_port_e'(p)) & laneMask(sel_i);
      next_dir[p] = dirReg[p];
      next_out[p] = outReg[p];
      if (wrCommit && (hitPort == gpd_pkg::gpd_port_e'(p))) begin
        next_dir[p] = (dirReg[p] & ~wm[31:24]) | (dat_i[31:24] & wm[31:24]);
        next_out[p] = (outReg[p] & ~wm[23:16]) | (dat_i[23:16] & wm[23:16]);
      end
    end

    always_ff @(posedge clock or negedge rstSyncN) begin
      if (!rstSyncN) begin
        dirReg[p] <= `GPD_DIR_RESET;
        outReg[p] <= `GPD_OUT_RESET;
      end else begin
        dirReg[p] <= next_dir[p];
        outReg[p] <= next_out[p];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive, straight from the field flip-flops

  // Output value is driven even while the pin is an input; the enable gates it
  always_comb begin
    p0PinOe  = dirReg[0][`GPD_P0_PINS-1:0];
    p0PinOut = outReg[0][`GPD_P0_PINS-1:0];
    p1PinOe  = dirReg[1][`GPD_P1_PINS-1:0];
    p1PinOut = outReg[1][`GPD_P1_PINS-1:0];
    p2PinOe  = dirReg[2][`GPD_P2_PINS-1:0];
    p2PinOut = outReg[2][`GPD_P2_PINS-1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstSyncN);

  a_ack_single_pulse: assert property (
    ack_o |=> !ack_o)
    else $error("ack held for more than one cycle");

  a_ack_follows_req: assert property (
    (cyc_i && stb_i && !ack_o) |=> ack_o)
    else $error("request not answered in one cycle");

  a_p0_dir_write: assert property (
    (wrCommit && hitPort == gpd_pkg::GPD_PORT0 && sel_i[3])
      |=> (p0PinOe == $past(dat_i[28:24])))
    else $error("port0 direction not taken from write");

  a_p0_out_write: assert property (
    (wrCommit && hitPort == gpd_pkg::GPD_PORT0 && sel_i[2])
      |=> (p0PinOut == $past(dat_i[20:16])))
    else $error("port0 output not taken from write");

  a_p0_status_read: assert property (
    (cyc_i && stb_i && !we_i && !ack_o && hitPort == gpd_pkg::GPD_PORT0)
      |=> (dat_o[4:0] == $past(pinLevel[4:0])) && (dat_o[15:5] == 11'h000))
    else $error("port0 status bits do not show pin levels");

  a_p1_dir_write: assert property (
    (wrCommit && hitPort == gpd_pkg::GPD_PORT1 && sel_i[3])
      |=> (p1PinOe == $past(dat_i[25:24])))
    else $error("port1 direction not taken from write");

  a_p1_out_write: assert property (
    (wrCommit && hitPort == gpd_pkg::GPD_PORT1 && sel_i[2])
      |=> (p1PinOut == $past(dat_i[17:16])))
    else $error("port1 output not taken from write");

  a_p1_status_read: assert property (
    (cyc_i && stb_i && !we_i && !ack_o && hitPort == gpd_pkg::GPD_PORT1)
      |=> (dat_o[1:0] == $past(pinLevel[6:5])) && (dat_o[31:26] == 6'h00))
    else $error("port1 status bits do not show pin levels");

  a_p2_gap_pins: assert property (
    (p2PinOe[3:2] == 2'h0) && (p2PinOut[4:2] == 3'h0))
    else $error("port2 unimplemented pin bits became active");

  a_p2_read_map: assert property (
    (cyc_i && stb_i && !we_i && !ack_o && hitPort == gpd_pkg::GPD_PORT2)
      |=> (dat_o[30:24] == {$past(dirReg[2][6:4]), 2'h0, $past(dirReg[2][1:0])})
          && (dat_o[6:0] == {$past(pinLevel[13:11]), 2'h0, $past(pinLevel[8:7])}))
    else $error("port2 read word mismatched");

  a_no_stray_write: assert property (
    (!(wrCommit && hitPort == gpd_pkg::GPD_PORT0)) |=> $stable(p0PinOe) && $stable(p0PinOut))
    else $error("port0 changed without a write");

  a_reset_inputs: assert property (
    $rose(rstSyncN) |-> (p0PinOe == 5'h00) && (p1PinOe == 2'h0) && (p2PinOe == 7'h00))
    else $error("pins not inputs after reset");

  // Port2 fields are sparse, so the pin vectors are rebuilt around the gap
  a_p2_dir_write: assert property (
    (wrCommit && hitPort == gpd_pkg::GPD_PORT2 && sel_i[3])
      |=> (p2PinOe == {$past(dat_i[30:28]), 2'h0, $past(dat_i[25:24])}))
    else $error("port2 direction not taken from write");

  a_p2_out_write: assert property (
    (wrCommit && hitPort == gpd_pkg::GPD_PORT2 && sel_i[2])
      |=> (p2PinOut == {$past(dat_i[22:21]), 3'h0, $past(dat_i[17:16])}))
    else $error("port2 output not taken from write");

  // A byte with its enable low must leave its field alone
  a_p1_lane_skip: assert property (
    (wrCommit && hitPort == gpd_pkg::GPD_PORT1 && !sel_i[3]) |=> $stable(p1PinOe))
    else $error("port1 direction changed by a disabled byte");

  a_unmapped_zero: assert property (
    (cyc_i && stb_i && !ack_o && hitPort == gpd_pkg::GPD_NONE) |=> (dat_o == 32'h00000000))
    else $error("unmapped access returned nonzero data");

  // Read data must not move under a master that samples it late
  a_read_hold: assert property (
    !(cyc_i && stb_i && !ack_o) |=> $stable(dat_o))
    else $error("read data changed without a request");

  a_ack_needs_req: assert property (
    ack_o |-> $past(busReq) && !$past(ack_o))
    else $error("ack without a taken request");

endmodule

// *** bench/gpd_pin_model.sv ***
/*
  External circuitry on one general-purpose port: a weak source per pin
  that the device overrides wherever it enables its own driver.
  Assumes the bench sets the external levels and reads the wire levels.
*/
module gpd_pin_model #(
  parameter int W = 5
) (
  input  wire logic [W-1:0] pinOe,
  input  wire logic [W-1:0] pinOut,
  input  wire logic [W-1:0] extDrive,
  output logic      [W-1:0] pinLevel
);
  timeunit 1ns;
  timeprecision 1ps;
  // Device driver wins; elsewhere the outside source sets the level
  assign pinLevel = (pinOe & pinOut) | (~pinOe & extDrive);
endmodule

// *** bench/gpd_port_regs_tb.sv ***
/*
  Self-checking bench for the port pin-control registers.
  Assumes a Wishbone ack one cycle after a request and 2-flop pin sync.
*/
`include "gpd_map.svh"

module gpd_port_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clock = 1'b0;
  logic        nrst  = 1'b0;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [31:0] adr   = 32'h00000000;
  logic [3:0]  sel   = 4'h0;
  logic [31:0] datW  = 32'h00000000;
  logic [31:0] datR;
  logic        ack;
  logic [4:0]  p0Ext = 5'h15;
  logic [1:0]  p1Ext = 2'h2;
  logic [6:0]  p2Ext = 7'h5A;
  logic [4:0]  p0Pin, p0Out, p0Oe;
  logic [1:0]  p1Pin, p1Out, p1Oe;
  logic [6:0]  p2Pin, p2Out, p2Oe;
  int          num_errors = 0;
  int          checks     = 0;

  always #4 clock = ~clock;

  gpd_port_regs dut (.clock(clock), .nrst(nrst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(datW), .dat_o(datR), .ack_o(ack),
    .p0PinIn(p0Pin), .p0PinOut(p0Out), .p0PinOe(p0Oe), .p1PinIn(p1Pin),
    .p1PinOut(p1Out), .p1PinOe(p1Oe), .p2PinIn(p2Pin), .p2PinOut(p2Out), .p2PinOe(p2Oe));
  gpd_pin_model #(.W(5)) ext0 (.pinOe(p0Oe), .pinOut(p0Out), .extDrive(p0Ext), .pinLevel(p0Pin));
  gpd_pin_model #(.W(2)) ext1 (.pinOe(p1Oe), .pinOut(p1Out), .extDrive(p1Ext), .pinLevel(p1Pin));
  gpd_pin_model #(.W(7)) ext2 (.pinOe(p2Oe), .pinOut(p2Out), .extDrive(p2Ext), .pinLevel(p2Pin));

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (num_errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_pin(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t pins=%h exp=%h", $time, got, exp);
    end
  endtask

  // Called just after a rising edge; returns one edge after the ack edge
  task automatic xfer(input logic w, input logic [31:0] a, input logic [3:0] s,
                      input logic [31:0] d, output logic [31:0] q);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= s;
    datW <= d;
    // Only the watchdog ends a wait for ack
    do begin
      @(posedge clock);
    end while (ack !== 1'b1);
    q = datR;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clock);
  endtask

  // Read after the pin level has crossed the synchroniser
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    repeat (3) @(posedge clock);
    xfer(1'b0, a, 4'hF, 32'h00000000, q);
    cmp(q, exp);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, 4'hF, d, q);
  endtask

  task automatic wr_sel(input logic [31:0] a, input logic [3:0] s, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, s, d, q);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    repeat (4) @(posedge clock);
    cmp_pin({4'h0, p2Oe, p1Oe, p0Oe, p2Out, p1Out, p0Out}, 32'h00000000);
    rd_chk(`GPD_PORT0_ADDR, 32'h00000015);
    rd_chk(`GPD_PORT1_ADDR, 32'h00000002);
    rd_chk(`GPD_PORT2_ADDR, 32'h00000052);
    // Every pin driven: readback shows the device's own drive
    wr(`GPD_PORT0_ADDR, 32'h1F0A0000);
    cmp_pin({22'h000000, p0Oe, p0Out}, 32'h000003EA);
    rd_chk(`GPD_PORT0_ADDR, 32'h1F0A000A);
    // Mixed directions: pins 0 and 2 driven, the rest follow outside
    wr(`GPD_PORT0_ADDR, 32'h05130000);
    rd_chk(`GPD_PORT0_ADDR, 32'h05130011);
    wr(`GPD_PORT1_ADDR, 32'h02030000);
    cmp_pin({28'h0000000, p1Oe, p1Out}, 32'h0000000B);
    rd_chk(`GPD_PORT1_ADDR, 32'h02030002);
    wr(`GPD_PORT2_ADDR, 32'h73630000);
    cmp_pin({18'h00000, p2Oe, p2Out}, 32'h000039E3);
    rd_chk(`GPD_PORT2_ADDR, 32'h73630063);
    // Ones into status bits are refused; the zero upper bytes of the word clear direction and output
    wr(`GPD_PORT0_ADDR, 32'h0000001F);
    rd_chk(`GPD_PORT0_ADDR, 32'h00000015);
    p0Ext <= 5'h0A;
    rd_chk(`GPD_PORT0_ADDR, 32'h0000000A);
    // Unmapped neighbour must not reach the port0 or port1 word
    wr(32'hFFFF0D24, 32'h1F1F0000);
    rd_chk(32'hFFFF0D24, 32'h00000000);
    rd_chk(`GPD_PORT0_ADDR, 32'h0000000A);
    rd_chk(`GPD_PORT1_ADDR, 32'h02030002);
    // Output lane only: the direction byte is held back by its enable
    wr_sel(`GPD_PORT1_ADDR, 4'h4, 32'h01010000);
    cmp_pin({28'h0000000, p1Oe, p1Out}, 32'h00000009);
    rd_chk(`GPD_PORT1_ADDR, 32'h02010000);
    // Reset in mid-run returns every pin to input
    nrst <= 1'b0;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    repeat (4) @(posedge clock);
    cmp_pin({4'h0, p2Oe, p1Oe, p0Oe, p2Out, p1Out, p0Out}, 32'h00000000);
    rd_chk(`GPD_PORT1_ADDR, 32'h00000002);
    report_and_stop();
  end

  // Whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clock);
    num_errors++;
    report_and_stop();
  end
endmodule
